// *** include/pspm_pkg.sv ***
package pspm_pkg;

    localparam int PC_W        = 12;
    localparam int PAGE_W      = 2;
    localparam int OFS_W       = 11;
    localparam int PHYS_W      = 13;
    localparam int DADDR_W     = 8;
    localparam int DATA_W      = 8;
    localparam int STACK_DEPTH = 6;
    localparam int SP_W        = 3;

    localparam logic [DADDR_W-1:0] PAGE_SEL_ADDR = 8'hCA;
    localparam logic [PAGE_W-1:0]  STATIC_PAGE   = 2'h1;
    localparam logic [PAGE_W-1:0]  PAGE_SEL_RST  = 2'h0;
    localparam int                 STATIC_MSB    = 11;

    localparam logic [PC_W-1:0] IRQ_VEC_BASE = 12'hFF0;
    localparam logic [PC_W-1:0] NMI_VEC_ADDR = 12'hFFC;
    localparam logic [PC_W-1:0] RST_VEC_ADDR = 12'hFFE;
    localparam logic [PC_W-1:0] PC_RST       = 12'h000;
    localparam logic [SP_W-1:0] SP_RST       = 3'h0;

    // request from the core's fetch logic
    typedef struct packed {
        logic            valid;
        logic [PC_W-1:0] program_counter;
    } pspm_fetch_type;

    // data-space write from the core
    typedef struct packed {
        logic               wr_en;
        logic               bit_op;
        logic [DADDR_W-1:0] addr;
        logic [DATA_W-1:0]  data;
    } pspm_dwrite_type;

    typedef enum logic [1:0] {
        ST_RESET = 2'b00,
        ST_VECT  = 2'b01,
        ST_RUN   = 2'b11
    } pspm_state_type;

endpackage : pspm_pkg

// *** verilog/pspm_stack.sv ***
`timescale 1ns/1ps
module pspm_stack
    import pspm_pkg::*;
(
    input  wire logic            ref_clk,
    input  wire logic            reset_n,
    input  wire logic            push,
    input  wire logic            pop,
    input  wire logic [PC_W-1:0] push_addr,
    output logic      [PC_W-1:0] top_addr,
    output logic      [SP_W-1:0] depth
);
    logic [PC_W-1:0] level_q [STACK_DEPTH];
    logic [SP_W-1:0] depth_q;

    // shift register: deepest entry falls off when full
    always_ff @(posedge ref_clk)
    begin
        if (push)
        begin
            level_q[0] <= push_addr;
            for (int i = 1; i < STACK_DEPTH; i++)
                level_q[i] <= level_q[i-1];
        end
        else if (pop)
        begin
            for (int i = 0; i < STACK_DEPTH - 1; i++)
                level_q[i] <= level_q[i+1];
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (!reset_n)
            depth_q <= SP_RST;
        else if (push && depth_q != SP_W'(STACK_DEPTH))
            depth_q <= depth_q + 3'h1;
        else if (pop && !push && depth_q != SP_RST)
            depth_q <= depth_q - 3'h1;
    end

    assign top_addr = level_q[0];
    assign depth    = depth_q;

endmodule : pspm_stack

// *** verilog/pspm_mapper.sv ***
`timescale 1ns/1ps
// Functional notes
// RQ1 - core program address is twelve bits
// RQ2 - four physical pages of 2 Kbytes
// RQ3 - lower half uses selected page
// RQ4 - counter top bit forces static page
// RQ5 - static page also reachable via lower half
// RQ6 - software changes pages through static page
// RQ7 - vectors are fetched from static page
// RQ8 - six-level return address stack
// RQ9 - falling edge on nmi requests service
// RQ10 - reset restarts through reset vector
// RQ11 - two-bit page number encodes pages 0-3
// RQ12 - page select write-only at CAh
// RQ13 - calls and interrupts keep page select
// RQ14 - physical address is page plus eleven bits
module pspm_mapper
    import pspm_pkg::*;
(
    input  wire logic            ref_clk,
    input  wire logic            reset_n,
    input  wire pspm_fetch_type  fetch,
    input  wire pspm_dwrite_type dwrite,
    input  wire logic            nmi_n,
    input  wire logic            irq_take,
    input  wire logic [1:0]      irq_index,
    input  wire logic            ret_take,
    input  wire logic            call_take,
    input  wire logic [PC_W-1:0] ret_addr,
    output logic [PHYS_W-1:0]    phys_addr_q,
    output logic                 phys_valid_q,
    output logic [PAGE_W-1:0]    program_page_select_q,
    output logic                 nmi_pending_q,
    output logic                 vector_fetch_q,
    output logic [PC_W-1:0]      vector_addr_q,
    output logic [PC_W-1:0]      stack_top_q,
    output logic [SP_W-1:0]      stack_depth_q
);

    ////////////////////////////////////////////////////////////////////
    // page decode

    // used for fetches and for the vector path
    function automatic logic [PAGE_W-1:0] pick_page(
        input logic [PC_W-1:0]   pc,
        input logic [PAGE_W-1:0] page_number_field);
        if (pc[STATIC_MSB])
            pick_page = STATIC_PAGE; // [RQ4]
        else
            pick_page = page_number_field; // [RQ3] [RQ5] [RQ11]
    endfunction : pick_page

    function automatic logic [PHYS_W-1:0] map_addr(
        input logic [PC_W-1:0]   pc,
        input logic [PAGE_W-1:0] sel);
        map_addr = {pick_page(pc, sel), pc[OFS_W-1:0]}; // [RQ14] [RQ2]
    endfunction : map_addr

    ////////////////////////////////////////////////////////////////////
    // page select register

    logic page_wr;
    // bit instructions are ignored rather than merged: no readback exists
    assign page_wr = dwrite.wr_en && !dwrite.bit_op
                     && dwrite.addr == PAGE_SEL_ADDR; // [RQ12]

    // undefined after reset in silicon; held at a known value here
    always_ff @(posedge ref_clk)
    begin
        if (!reset_n)
            program_page_select_q <= PAGE_SEL_RST;
        else if (page_wr)
            program_page_select_q <= dwrite.data[PAGE_W-1:0]; // [RQ13]
    end

    ////////////////////////////////////////////////////////////////////
    // nmi edge detect and sequencing

    logic           nmi_q;
    logic           nmi_fall;
    pspm_state_type state_q;

    assign nmi_fall = nmi_q && !nmi_n; // [RQ9]

    always_ff @(posedge ref_clk)
    begin
        if (!reset_n)
            nmi_q <= 1'b1;
        else
            nmi_q <= nmi_n;
    end

    // set wins over the clear taken by the vector fetch
    always_ff @(posedge ref_clk)
    begin
        if (!reset_n)
            nmi_pending_q <= 1'b0;
        else if (nmi_fall)
            nmi_pending_q <= 1'b1; // [RQ9]
        else if (state_q == ST_RUN)
            nmi_pending_q <= 1'b0;
    end

    always_ff @(posedge ref_clk)
    begin
        if (!reset_n)
            state_q <= ST_RESET;
        else
            case (state_q)
                ST_RESET: state_q <= ST_VECT;
                ST_VECT:  state_q <= ST_RUN;
                ST_RUN:   state_q <= ST_RUN;
                default:  state_q <= ST_RESET;
            endcase
    end

    ////////////////////////////////////////////////////////////////////
    // vector selection and physical address

    logic [PC_W-1:0] vec_d;
    logic            vec_go;

    always_comb
    begin
        vec_go = 1'b1;
        vec_d  = RST_VEC_ADDR; // [RQ10]
        if (state_q == ST_RUN)
        begin
            if (nmi_pending_q)
                vec_d = NMI_VEC_ADDR; // [RQ9] [RQ7]
            else if (irq_take)
                vec_d = IRQ_VEC_BASE | {9'h000, irq_index, 1'b0}; // [RQ7]
            else
                vec_go = 1'b0;
        end
        else if (state_q == ST_RESET)
            vec_go = 1'b0;
    end

    always_ff @(posedge ref_clk)
    begin
        if (!reset_n)
        begin
            phys_addr_q    <= {PHYS_W{1'b0}};
            phys_valid_q   <= 1'b0;
            vector_fetch_q <= 1'b0;
            vector_addr_q  <= PC_RST;
        end
        else
        begin
            vector_fetch_q <= vec_go;
            vector_addr_q  <= vec_go ? vec_d : PC_RST;
            phys_valid_q   <= vec_go || fetch.valid;
            if (vec_go)
                phys_addr_q <= map_addr(vec_d, program_page_select_q); // [RQ7]
            else
                phys_addr_q <= map_addr(fetch.program_counter,
                                        program_page_select_q); // [RQ1]
        end
    end

    ////////////////////////////////////////////////////////////////////
    // return stack

    logic [PC_W-1:0] top_w;
    logic [SP_W-1:0] depth_w;

    pspm_stack u_stack (
        .ref_clk   (ref_clk),
        .reset_n   (reset_n),
        .push      (call_take || (vec_go && state_q == ST_RUN)), // [RQ8]
        .pop       (ret_take),
        .push_addr (ret_addr),
        .top_addr  (top_w),
        .depth     (depth_w)
    );

    always_ff @(posedge ref_clk)
    begin
        if (!reset_n)
        begin
            stack_top_q   <= PC_RST;
            stack_depth_q <= SP_RST;
        end
        else
        begin
            stack_top_q   <= top_w;
            stack_depth_q <= depth_w;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // checks

    a_static_top: assert property ( // [RQ4]
        @(posedge ref_clk) disable iff (!reset_n)
        fetch.valid && !vec_go && fetch.program_counter[STATIC_MSB]
        |=> phys_addr_q[PHYS_W-1:OFS_W] == STATIC_PAGE)
        else $error("upper half not mapped to static page");

    a_low_half_page: assert property ( // [RQ3]
        @(posedge ref_clk) disable iff (!reset_n)
        fetch.valid && !vec_go && !fetch.program_counter[STATIC_MSB]
        |=> phys_addr_q[PHYS_W-1:OFS_W]
            == $past(program_page_select_q))
        else $error("lower half ignores page select");

    a_offset_kept: assert property ( // [RQ14]
        @(posedge ref_clk) disable iff (!reset_n)
        fetch.valid && !vec_go
        |=> phys_addr_q[OFS_W-1:0]
            == $past(fetch.program_counter[OFS_W-1:0]))
        else $error("offset bits not passed through");

    a_page_write: assert property ( // [RQ12]
        @(posedge ref_clk) disable iff (!reset_n)
        page_wr
        |=> program_page_select_q == $past(dwrite.data[PAGE_W-1:0]))
        else $error("page select write lost");

    a_page_hold: assert property ( // [RQ13]
        @(posedge ref_clk) disable iff (!reset_n)
        !page_wr |=> $stable(program_page_select_q))
        else $error("page select changed without write");

    // no disable here: the antecedent spans the reset release itself
    a_reset_vector: assert property ( // [RQ10]
        @(posedge ref_clk)
        !reset_n ##1 reset_n |=> ##1 vector_fetch_q
        && vector_addr_q == RST_VEC_ADDR)
        else $error("reset vector not fetched");

    a_nmi_vector: assert property ( // [RQ9]
        @(posedge ref_clk) disable iff (!reset_n)
        nmi_fall && state_q == ST_RUN |=> ##1 vector_fetch_q
        && vector_addr_q == NMI_VEC_ADDR)
        else $error("nmi not vectored");

    a_vector_static: assert property ( // [RQ7]
        @(posedge ref_clk) disable iff (!reset_n)
        vector_fetch_q |-> phys_addr_q[PHYS_W-1:OFS_W] == STATIC_PAGE)
        else $error("vector fetched outside static page");

    a_stack_bound: assert property ( // [RQ8]
        @(posedge ref_clk) disable iff (!reset_n)
        stack_depth_q <= SP_W'(STACK_DEPTH))
        else $error("stack depth above six");

    c_page_switch: cover property (@(posedge ref_clk) disable iff (!reset_n)
        page_wr ##1 fetch.valid && !fetch.program_counter[STATIC_MSB]);
    c_nmi_taken: cover property (@(posedge ref_clk) disable iff (!reset_n)
        nmi_fall ##2 vector_fetch_q);
    c_irq_taken: cover property (@(posedge ref_clk) disable iff (!reset_n)
        irq_take && state_q == ST_RUN && !nmi_pending_q);
    c_stack_full: cover property (@(posedge ref_clk) disable iff (!reset_n)
        stack_depth_q == SP_W'(STACK_DEPTH));

endmodule : pspm_mapper

// *** sim/pspm_core_model.sv ***
`timescale 1ns/1ps
module pspm_core_model
    import pspm_pkg::*;
(
    input  wire logic      ref_clk,
    output pspm_fetch_type fetch
);
    initial fetch = '0;

    // request held from one falling edge to the next, one rising edge inside
    task automatic issue(input logic [PC_W-1:0] pc);
        @(negedge ref_clk);
        fetch.valid           = 1'b1;
        fetch.program_counter = pc;
        @(negedge ref_clk);
        fetch.valid           = 1'b0;
        // idle address inverted so a stale value never passes for a match
        fetch.program_counter = ~pc;
    endtask : issue
endmodule : pspm_core_model

// *** sim/tb_program_space_page_mapper.sv ***
`timescale 1ns/1ps
module tb_program_space_page_mapper
    import pspm_pkg::*;
;
    logic                 ref_clk = 1'b0;
    logic                 reset_n = 1'b0;
    pspm_fetch_type       fetch;
    pspm_dwrite_type      dwrite  = '0;
    logic                 nmi_n   = 1'b1;
    logic                 irq_take = 1'b0;
    logic [1:0]           irq_index = 2'h0;
    logic                 ret_take = 1'b0;
    logic                 call_take = 1'b0;
    logic [PC_W-1:0]      ret_addr = 12'h000;
    logic [PHYS_W-1:0]    phys_addr_q;
    logic                 phys_valid_q;
    logic [PAGE_W-1:0]    sel_q;
    logic                 nmi_pending_q;
    logic                 vector_fetch_q;
    logic [PC_W-1:0]      vector_addr_q;
    logic [PC_W-1:0]      stack_top_q;
    logic [SP_W-1:0]      stack_depth_q;
    int                   err_count = 0;
    int                   n_checks  = 0;

    always #2.5 ref_clk = ~ref_clk;

    pspm_core_model u_core (.ref_clk(ref_clk), .fetch(fetch));

    pspm_mapper u_dut (
        .ref_clk(ref_clk), .reset_n(reset_n), .fetch(fetch),
        .dwrite(dwrite), .nmi_n(nmi_n), .irq_take(irq_take),
        .irq_index(irq_index), .ret_take(ret_take),
        .call_take(call_take), .ret_addr(ret_addr),
        .phys_addr_q(phys_addr_q), .phys_valid_q(phys_valid_q),
        .program_page_select_q(sel_q), .nmi_pending_q(nmi_pending_q),
        .vector_fetch_q(vector_fetch_q), .vector_addr_q(vector_addr_q),
        .stack_top_q(stack_top_q), .stack_depth_q(stack_depth_q)
    );

    ////////////////////////////////////////////////////////////////////////
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : end_of_test

    task automatic chk(input logic [15:0] exp, input logic [15:0] got);
        n_checks++;
        if (got !== exp)
        begin
            err_count++;
            $display("[ERR] t=%0t exp=%h got=%h", $time, exp, got);
        end
    endtask : chk

    task automatic fetch_chk(input logic [11:0] pc, input logic [12:0] exp);
        u_core.issue(pc);
        chk(16'(exp), 16'(phys_addr_q));
        chk(16'h0001, 16'(phys_valid_q));
    endtask : fetch_chk

    task automatic wr_sel(input logic [7:0] a, input logic [7:0] d,
                          input logic b);
        @(negedge ref_clk);
        dwrite.addr   = a;
        dwrite.data   = d;
        dwrite.bit_op = b;
        dwrite.wr_en  = 1'b1;
        @(negedge ref_clk);
        dwrite.wr_en  = 1'b0;
    endtask : wr_sel

    ////////////////////////////////////////////////////////////////////////
    task automatic test_reset();
        repeat (10) @(negedge ref_clk);
        chk(16'h0000, 16'(vector_fetch_q));
        reset_n = 1'b1;
        repeat (2) @(negedge ref_clk);
        chk(16'h0001, 16'(vector_fetch_q));
        chk(16'h0FFE, 16'(vector_addr_q));
        chk(16'h0FFE, 16'(phys_addr_q));
        $display("done reset");
    endtask : test_reset

    task automatic test_pages();
        for (int p = 0; p < 4; p++)
        begin
            fetch_chk(12'h9A5, 13'h09A5);
            wr_sel(8'hCA, {6'h3F, p[1:0]}, 1'b0);
            chk(16'(p), 16'(sel_q));
            fetch_chk(12'h3A5, {p[1:0], 11'h3A5});
            fetch_chk(12'hFA5, 13'h0FA5);
        end
        $display("done pages");
    endtask : test_pages

    task automatic test_refuse();
        wr_sel(8'hCA, 8'h00, 1'b1);
        wr_sel(8'hCB, 8'h00, 1'b0);
        chk(16'h0003, 16'(sel_q));
        chk(16'h0000, 16'(vector_fetch_q));
        chk(16'h0000, 16'(vector_addr_q));
        $display("done refuse");
    endtask : test_refuse

    task automatic test_nmi();
        @(negedge ref_clk);
        nmi_n = 1'b0;
        @(negedge ref_clk);
        chk(16'h0001, 16'(nmi_pending_q));
        // a maskable request in the same cycle must lose to the nmi
        irq_index = 2'h3;
        irq_take  = 1'b1;
        @(negedge ref_clk);
        irq_take  = 1'b0;
        chk(16'h0001, 16'(vector_fetch_q));
        chk(16'h0FFC, 16'(vector_addr_q));
        chk(16'h0000, 16'(nmi_pending_q));
        chk(16'h0FFC, 16'(phys_addr_q));
        chk(16'h0003, 16'(sel_q));
        nmi_n = 1'b1;
        $display("done nmi");
    endtask : test_nmi

    task automatic test_irq();
        for (int i = 0; i < 4; i++)
        begin
            @(negedge ref_clk);
            irq_index = i[1:0];
            irq_take  = 1'b1;
            @(negedge ref_clk);
            irq_take  = 1'b0;
            chk(16'h0001, 16'(vector_fetch_q));
            chk(16'h0FF0 + 16'(2 * i), 16'(vector_addr_q));
        end
        chk(16'h0003, 16'(sel_q));
        $display("done irq");
    endtask : test_irq

    task automatic test_stack();
        // eight pushes overrun six levels whatever depth vectors left
        for (int i = 0; i < 8; i++)
        begin
            @(negedge ref_clk);
            call_take = 1'b1;
            ret_addr  = 12'h100 + 12'(i);
        end
        @(negedge ref_clk);
        call_take = 1'b0;
        repeat (3) @(negedge ref_clk);
        chk(16'h0006, 16'(stack_depth_q));
        chk(16'h0107, 16'(stack_top_q));
        ret_take = 1'b1;
        @(negedge ref_clk);
        ret_take = 1'b0;
        repeat (3) @(negedge ref_clk);
        chk(16'h0005, 16'(stack_depth_q));
        chk(16'h0106, 16'(stack_top_q));
        ret_take = 1'b1;
        repeat (7) @(negedge ref_clk);
        ret_take = 1'b0;
        repeat (3) @(negedge ref_clk);
        chk(16'h0000, 16'(stack_depth_q));
        chk(16'h0003, 16'(sel_q));
        $display("done stack");
    endtask : test_stack

    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        #100000;
        err_count++;
        end_of_test();
    end

    initial
    begin
        test_reset();
        test_pages();
        test_refuse();
        test_nmi();
        test_irq();
        test_stack();
        end_of_test();
    end
endmodule : tb_program_space_page_mapper
